// *** core/aeps_pkg.sv ***
// Package with constants and types for the absolute encoder position select block.
package aeps_pkg;

    // ==========================================================
    // Encoder usage setting codes
    // ==========================================================
    localparam logic [1:0] AEPS_USE_NATIVE      = 2'h0;
    localparam logic [1:0] AEPS_USE_INCREMENTAL = 2'h1;
    localparam logic [1:0] AEPS_USE_SINGLE_TURN = 2'h2;

    // ==========================================================
    // Widths and reset values
    // ==========================================================
    localparam int         AEPS_TURN_W     = 16;
    localparam int         AEPS_PULSE_W    = 23;
    localparam int         AEPS_POS_W      = 40;
    localparam logic [1:0] AEPS_USAGE_RST  = 2'h0;

    // Native encoder type fitted to the motor.
    typedef enum logic [1:0] {
        AEPS_ENC_INCREMENTAL = 2'b00,
        AEPS_ENC_SINGLE_TURN = 2'b01,
        AEPS_ENC_MULTITURN   = 2'b10
    } aeps_enc_t;

    // Effective operating mode of the position path.
    typedef enum logic [1:0] {
        AEPS_MODE_INCREMENTAL = 2'b00,
        AEPS_MODE_SINGLE_TURN = 2'b01,
        AEPS_MODE_MULTITURN   = 2'b10
    } aeps_mode_t;

endpackage : aeps_pkg

// *** core/aeps_position_select.sv ***
// Encoder usage selection and absolute position forming.
`timescale 1ns/100ps

// Notes on behaviour
// - Default setting uses encoder as its native type.
// - Setting one forces incremental, no absolute position.
// - Setting two makes absolute encoder single-turn.
// - Position kept as signed turns plus pulses.
// - Position equals turns times pulses-per-rotation plus pulses.
// - Single-turn operation forces turn count to zero.
// - Absolute mode reports retained stop position at start.
module aeps_position_select (
    input  wire logic                           clk_sys,
    input  wire logic                           reset,
    input  wire logic [1:0]                     encoder_usage_select,
    input  wire aeps_pkg::aeps_enc_t            enc_type,
    input  wire logic [31:0]                    encoder_pulses_per_rotation,
    input  wire logic signed [aeps_pkg::AEPS_TURN_W-1:0] enc_turns,
    input  wire logic [aeps_pkg::AEPS_PULSE_W-1:0]       enc_pulse_pos,
    input  wire logic                           enc_valid,
    output aeps_pkg::aeps_mode_t                mode_q,
    output logic                                abs_valid_q,
    output logic signed [aeps_pkg::AEPS_TURN_W-1:0]      turns_q,
    output logic [aeps_pkg::AEPS_PULSE_W-1:0]   pulse_pos_q,
    output logic signed [aeps_pkg::AEPS_POS_W-1:0]       abs_pos_q
);
    import aeps_pkg::*;

    // ==========================================================
    // Restart sampling
    // ==========================================================
    // The setting is caught on the first clock after reset release, never under
    // the asynchronous reset itself, so reset loads only constants.
    // armed_q closes the sampling window after that one edge; from then on the
    // setting and the fitted encoder type are frozen until the next reset.
    // A user who rewrites the setting while running sees no change in the mode,
    // because this setting is a restart-only value.
    // The fitted encoder type is frozen with it, so a cable swap under power
    // cannot switch the position path between absolute and incremental.
    logic       armed_q;
    logic [1:0] usage_q;
    aeps_enc_t  enc_type_q;

    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            armed_q    <= 1'b0;
            usage_q    <= AEPS_USAGE_RST;
            enc_type_q <= AEPS_ENC_INCREMENTAL;
        end else if (!armed_q) begin
            armed_q    <= 1'b1;
            usage_q    <= encoder_usage_select;
            enc_type_q <= enc_type;
        end
    end

    // Resolves the effective mode from setting and fitted encoder.
    // Setting two only narrows an absolute encoder; an incremental encoder has
    // no retained turn count to drop, so it stays incremental.
    // Code three is not defined and falls back to incremental, the safe choice
    // because it never claims an absolute position it cannot back up.
    function automatic aeps_mode_t mode_of(input logic [1:0] use_sel, input aeps_enc_t enc);
        aeps_mode_t m;
        m = AEPS_MODE_INCREMENTAL;
        case (use_sel)
            AEPS_USE_NATIVE: begin
                case (enc)
                    AEPS_ENC_MULTITURN:   m = AEPS_MODE_MULTITURN;
                    AEPS_ENC_SINGLE_TURN: m = AEPS_MODE_SINGLE_TURN;
                    default:              m = AEPS_MODE_INCREMENTAL;
                endcase
            end
            AEPS_USE_SINGLE_TURN: begin
                if (enc != AEPS_ENC_INCREMENTAL) begin
                    m = AEPS_MODE_SINGLE_TURN;
                end
            end
            default: m = AEPS_MODE_INCREMENTAL; // Setting one and unused codes.
        endcase
        return m;
    endfunction : mode_of

    // ==========================================================
    // Mode register
    // ==========================================================
    aeps_mode_t mode_d;
    assign mode_d = mode_of(usage_q, enc_type_q);

    // The mode settles one edge after sampling and is then constant until the
    // next reset, since its only sources are the frozen setting registers.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            mode_q <= AEPS_MODE_INCREMENTAL;
        end else begin
            mode_q <= mode_d;
        end
    end

    // ==========================================================
    // Position forming
    // ==========================================================
    // Both factors are widened to the full position width before the multiply,
    // so a large pulse count per rotation with many turns keeps every bit that
    // fits the result. The product is combinational; at 100 MHz a 40-bit
    // multiply is a timing hazard on slow parts, traded for one cycle of latency.
    // Results beyond the position width wrap; the host must keep turns times
    // pulses per rotation inside that range.
    logic signed [AEPS_TURN_W-1:0] turns_d;
    logic signed [AEPS_POS_W-1:0]  abs_pos_d;
    logic signed [AEPS_POS_W-1:0]  prod;

    // Zero-extends a pulse position to the signed position width.
    // The pulse position is never negative, so no sign bit is copied.
    function automatic logic signed [AEPS_POS_W-1:0] widen_pulse(
        input logic [AEPS_PULSE_W-1:0] p);
        return $signed({{(AEPS_POS_W-AEPS_PULSE_W){1'b0}}, p});
    endfunction : widen_pulse

    assign turns_d = (mode_q == AEPS_MODE_MULTITURN) ? enc_turns : '0;
    assign prod = AEPS_POS_W'(turns_d) * AEPS_POS_W'($signed({1'b0, encoder_pulses_per_rotation}));
    assign abs_pos_d = prod + widen_pulse(enc_pulse_pos);

    // Capture takes turns and pulses in the same cycle so the pair never tears.
    // Without new encoder data the last capture stands, which is the retained
    // stop position the host reads after power returns.
    // turns and pulses held separately
    // stop position reported once encoder data is valid
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            abs_valid_q <= 1'b0;
            turns_q     <= '0;
            pulse_pos_q <= '0;
            abs_pos_q   <= '0;
        end else if (armed_q && enc_valid && mode_q != AEPS_MODE_INCREMENTAL) begin
            abs_valid_q <= 1'b1;
            turns_q     <= turns_d;
            pulse_pos_q <= enc_pulse_pos;
            abs_pos_q   <= abs_pos_d;
        end else if (mode_q == AEPS_MODE_INCREMENTAL) begin
            abs_valid_q <= 1'b0;
            turns_q     <= '0;
            pulse_pos_q <= '0;
            abs_pos_q   <= '0;
        end
    end

    // ==========================================================
    // Checks
    // ==========================================================
    // Every check is disabled under reset; the mode and the frozen setting are
    // reloaded there, so comparisons across a reset edge mean nothing.
    // Checks on the mode use |=> because mode_q follows the frozen setting by
    // one edge.
    setting_held_a: assert property (@(posedge clk_sys) disable iff (reset)
        armed_q && $past(armed_q) |-> $stable(usage_q))
        else $error("Usage setting changed after restart.");
    incr_no_abs_a: assert property (@(posedge clk_sys) disable iff (reset)
        mode_q == AEPS_MODE_INCREMENTAL |=> !abs_valid_q)
        else $error("Absolute position reported in incremental mode.");
    single_zero_a: assert property (@(posedge clk_sys) disable iff (reset)
        abs_valid_q && mode_q == AEPS_MODE_SINGLE_TURN |-> turns_q == '0)
        else $error("Turn count not zero in single-turn mode.");
    sel_two_a: assert property (@(posedge clk_sys) disable iff (reset)
        usage_q == AEPS_USE_SINGLE_TURN && enc_type_q != AEPS_ENC_INCREMENTAL
        |=> mode_q == AEPS_MODE_SINGLE_TURN)
        else $error("Setting two did not give single-turn mode.");
    native_multi_a: assert property (@(posedge clk_sys) disable iff (reset)
        usage_q == AEPS_USE_NATIVE && enc_type_q == AEPS_ENC_MULTITURN
        |=> mode_q == AEPS_MODE_MULTITURN)
        else $error("Default setting did not keep multiturn mode.");
    pos_sum_a: assert property (@(posedge clk_sys) disable iff (reset)
        armed_q && enc_valid && mode_q != AEPS_MODE_INCREMENTAL
        |=> abs_pos_q == $past(abs_pos_d) && pulse_pos_q == $past(enc_pulse_pos))
        else $error("Absolute position not formed from turns and pulses.");
    turns_kept_a: assert property (@(posedge clk_sys) disable iff (reset)
        armed_q && enc_valid && mode_q == AEPS_MODE_MULTITURN
        |=> turns_q == $past(enc_turns))
        else $error("Turn count not kept in multiturn mode.");
    report_valid_a: assert property (@(posedge clk_sys) disable iff (reset)
        armed_q && enc_valid && mode_q != AEPS_MODE_INCREMENTAL |=> abs_valid_q)
        else $error("Stop position not reported in absolute mode.");

    // Setting one, code three and native single-turn mappings, and the cleared outputs of incremental use.
    // Single-turn reports must equal the bare pulse position.
    incr_forced_a: assert property (@(posedge clk_sys) disable iff (reset)
        armed_q && usage_q != AEPS_USE_NATIVE && usage_q != AEPS_USE_SINGLE_TURN
        |=> mode_q == AEPS_MODE_INCREMENTAL)
        else $error("Setting one did not force incremental mode.");
    incr_clear_a: assert property (@(posedge clk_sys) disable iff (reset)
        mode_q == AEPS_MODE_INCREMENTAL
        |=> turns_q == '0 && pulse_pos_q == '0 && abs_pos_q == '0)
        else $error("Position outputs not cleared in incremental mode.");
    native_single_a: assert property (@(posedge clk_sys) disable iff (reset)
        usage_q == AEPS_USE_NATIVE && enc_type_q == AEPS_ENC_SINGLE_TURN
        |=> mode_q == AEPS_MODE_SINGLE_TURN)
        else $error("Default setting did not keep single-turn mode.");
    single_pos_a: assert property (@(posedge clk_sys) disable iff (reset)
        abs_valid_q && mode_q == AEPS_MODE_SINGLE_TURN
        |-> abs_pos_q == widen_pulse(pulse_pos_q))
        else $error("Single-turn position differs from pulse position.");
    unarmed_idle_a: assert property (@(posedge clk_sys) disable iff (reset)
        !armed_q |=> !abs_valid_q)
        else $error("Position reported before the setting was sampled.");

    // ==========================================================
    // Cover points
    // ==========================================================
    // The main scenarios: each absolute mode reporting, incremental idling,
    // a negative turn count and setting two in force.
    multi_cov_c:  cover property (@(posedge clk_sys) abs_valid_q && mode_q == AEPS_MODE_MULTITURN);
    neg_turns_c:  cover property (@(posedge clk_sys) abs_valid_q && turns_q < 0);
    sel_two_c:    cover property (@(posedge clk_sys) armed_q && usage_q == AEPS_USE_SINGLE_TURN);
    single_cov_c: cover property (@(posedge clk_sys) abs_valid_q && mode_q == AEPS_MODE_SINGLE_TURN);
    incr_cov_c:   cover property (@(posedge clk_sys) armed_q && mode_q == AEPS_MODE_INCREMENTAL);

endmodule : aeps_position_select

// *** test/aeps_encoder_model.sv ***
// Encoder model that presents a retained stop position to the block.
`timescale 1ns/100ps
module aeps_encoder_model (
    input  wire logic               clk_sys,
    input  wire logic signed [15:0] turns_set,
    input  wire logic [22:0]        pulse_set,
    output logic signed [15:0]      enc_turns,
    output logic [22:0]             enc_pulse_pos,
    output logic                    enc_valid
);
    // ==========================================================
    // Position output
    // ==========================================================
    // Data is valid from the first clock edge, since a backed-up encoder keeps its stop position.
    always_ff @(posedge clk_sys) begin
        enc_turns     <= turns_set;
        enc_pulse_pos <= pulse_set;
        enc_valid     <= 1'b1;
    end
endmodule : aeps_encoder_model

// *** test/test_absolute_encoder_position_select.sv ***
// Self-checking bench for the absolute encoder position select block.
`timescale 1ns/100ps
module test_absolute_encoder_position_select;
    import aeps_pkg::*;
    typedef struct {logic [1:0] u; aeps_enc_t e; aeps_mode_t m; logic v; logic signed [15:0] t;
                    logic signed [15:0] et;} aeps_row_t;
    logic                     clk_sys = 1'b0;
    logic                     reset   = 1'b1;
    logic [1:0]               usage   = 2'h0;
    aeps_enc_t                etype   = AEPS_ENC_MULTITURN;
    logic [31:0]              ppr     = 32'h3E8;
    logic signed [15:0]       t_set   = 16'h0;
    wire logic signed [15:0]  enc_turns;
    wire logic [22:0]         enc_pulse_pos;
    wire logic                enc_valid;
    aeps_mode_t               mode_q;
    logic                     abs_valid_q;
    logic signed [15:0]       turns_q;
    logic [22:0]              pulse_pos_q;
    logic signed [39:0]       abs_pos_q;
    int                       mismatches = 0;
    int                       compares   = 0;
    // Native type against setting; the single-turn rows expect a zero turn count.
    aeps_row_t rows [6] = '{'{2'h0, AEPS_ENC_MULTITURN, AEPS_MODE_MULTITURN, 1'b1, -16'sd3, -16'sd3},
        '{2'h0, AEPS_ENC_SINGLE_TURN, AEPS_MODE_SINGLE_TURN, 1'b1, 16'sd7, 16'sd0},
        '{2'h0, AEPS_ENC_INCREMENTAL, AEPS_MODE_INCREMENTAL, 1'b0, 16'sd7, 16'sd0},
        '{2'h1, AEPS_ENC_MULTITURN, AEPS_MODE_INCREMENTAL, 1'b0, 16'sd7, 16'sd0},
        '{2'h2, AEPS_ENC_MULTITURN, AEPS_MODE_SINGLE_TURN, 1'b1, 16'sd7, 16'sd0},
        '{2'h3, AEPS_ENC_MULTITURN, AEPS_MODE_INCREMENTAL, 1'b0, 16'sd7, 16'sd0}};

    always #5 clk_sys = ~clk_sys;

    aeps_encoder_model enc (.clk_sys(clk_sys), .turns_set(t_set), .pulse_set(23'h5),
        .enc_turns(enc_turns), .enc_pulse_pos(enc_pulse_pos), .enc_valid(enc_valid));
    aeps_position_select uut (.clk_sys(clk_sys), .reset(reset), .encoder_usage_select(usage),
        .enc_type(etype), .encoder_pulses_per_rotation(ppr), .enc_turns(enc_turns),
        .enc_pulse_pos(enc_pulse_pos), .enc_valid(enc_valid), .mode_q(mode_q),
        .abs_valid_q(abs_valid_q), .turns_q(turns_q), .pulse_pos_q(pulse_pos_q),
        .abs_pos_q(abs_pos_q));

    task check(input string n, input logic [39:0] e, input logic [39:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask : check

    // Setting is sampled on the first edge after release, so it is applied during reset.
    task restart(input logic [1:0] u, input aeps_enc_t e, input int hold);
        @(posedge clk_sys);
        reset <= 1'b1;
        usage <= u;
        etype <= e;
        repeat (hold) @(posedge clk_sys);
        reset <= 1'b0;
        repeat (4) @(posedge clk_sys);
        #1;
    endtask : restart

    task finish_test;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : finish_test

    // Whole run is near 0.6 us; the limit leaves ample margin.
    initial begin
        #20000;
        mismatches++;
        finish_test;
    end

    initial begin
        foreach (rows[i]) begin
            t_set <= rows[i].t;
            restart(rows[i].u, rows[i].e, (i == 0) ? 8 : 2);
            check("mode", rows[i].m, mode_q);
            check("valid", rows[i].v, abs_valid_q);
            check("turns", rows[i].et, turns_q);
            check("abs", rows[i].v ? 40'(longint'(rows[i].et) * ppr + 5) : 40'h0, abs_pos_q);
            $display("row test %0d done", i);
        end
        // Late setting change is ignored while extreme counts still combine correctly.
        restart(2'h0, AEPS_ENC_MULTITURN, 2);
        usage <= 2'h1;
        t_set <= 16'sh7FFF;
        ppr   <= 32'h0100_0000;
        repeat (4) @(posedge clk_sys);
        #1;
        check("mode", AEPS_MODE_MULTITURN, mode_q);
        check("abs", 40'(longint'(16'sh7FFF) * 32'h0100_0000 + 5), abs_pos_q);
        check("pulse", 40'h5, pulse_pos_q);
        $display("restart test done");
        finish_test;
    end
endmodule : test_absolute_encoder_position_select
